// *** mxc_pkg.sv ***
// Shared constants and carrier types for the multiplexed-address memory controller
`default_nettype none
package mxc_pkg;
  localparam int unsigned CLK_MHZ         = 20;     // System clock rate
  localparam int unsigned SETTLE_NS       = 30;     // Mode-set settle time, nanoseconds
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                                            (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DUMMY_MRS_COUNT = 3;      // Dummy mode sets at power-up
  localparam int unsigned INIT_IDLE_COUNT = 1024;   // Idle commands during initial refresh
  localparam int unsigned BANKS           = 8;      // Number of banks
  localparam int unsigned MUX_ENTRY_BIT   = 5;      // Address bit that selects multiplexed mode
  localparam int unsigned AW              = 22;     // Full logical address width
  localparam int unsigned PW              = 19;     // Address pins A0..A18
  localparam logic [3:0]  RC_CFG1         = 4'h4;   // Row cycle per configuration
  localparam logic [3:0]  RC_CFG2         = 4'h6;
  localparam logic [3:0]  RC_CFG3         = 4'h8;
  localparam logic [3:0]  RC_CFG4         = 4'h3;
  localparam logic [3:0]  RC_CFG5         = 4'h5;
  localparam logic [3:0]  RC_WR2RD_CFG4   = 4'h4;   // Write-to-read same bank in config 4
  // Command encodings on the command pins
  typedef enum logic [2:0] {
    MXC_NOP, MXC_MRS, MXC_AUTO_REFRESH_CMD, MXC_READ, MXC_WRITE
  } mxc_cmd_t;
  // Width and burst codes
  typedef enum logic [1:0] { MXC_X36, MXC_X18, MXC_X9 } mxc_width_t;
  typedef enum logic [1:0] { MXC_BL2, MXC_BL4, MXC_BL8 } mxc_burst_t;
  // One user request
  typedef struct packed {
    logic          isWrite;
    logic [2:0]    bank;
    logic [AW-1:0] addr;
  } mxc_req_t;
  // What goes onto the device pins in one cycle
  typedef struct packed {
    mxc_cmd_t      cmd;
    logic [2:0]    bank;
    logic [PW-1:0] addr;
  } mxc_pins_t;
endpackage
`default_nettype wire

// *** mxc_fifo.sv ***
// Request FIFO with valid and ready on both sides
`default_nettype none
module mxc_fifo #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             clockEnable,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned PTRW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Storage
  logic [PTRW-1:0]  wrPtr_reg;        // Write pointer
  logic [PTRW-1:0]  rdPtr_reg;        // Read pointer
  logic [PTRW:0]    count_reg;        // Occupancy
  logic             doWrite;
  logic             doRead;
  assign inReady  = (count_reg != (PTRW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign doWrite  = clockEnable && inValid && inReady;
  assign doRead   = clockEnable && outValid && outReady;
  // Storage writes carry no reset
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  // Pointer and count update
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == PTRW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == PTRW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PTRW+1)'(doWrite) - (PTRW+1)'(doRead);
    end
  end
endmodule
`default_nettype wire

// *** mxc_host.sv ***
// Controller that brings the memory into multiplexed mode and issues split-address commands
// What this block does
// - Mode set with A5 high enters multiplexed mode
// - Same entry also allowed later on request
// - Wait settle time before two-cycle mode set
// - Two-cycle mode set, first half A5 high
// - Drive A10 to A18 low on mode set
// - Fixed bits A0,A3,A4,A5,A8,A9 as prescribed
// - Reset DLL when clock or supply change
// - Power-up follows full ordered sequence
// - Address pins low on dummy mode sets
// - Eight bank refreshes among 1024 idles
// - Address split into two halves per ball
// - Upper bits placement depends on width, burst
// - No burst eight in configs one, four; the code only flags it on cfgError and holds back the entry mode set
// - Config four write-then-read same bank waits four
// - Next command right after auto refresh
// - Same bank only after row cycle time
`default_nettype none
// Overview: a power-up sequencer walks the device into split-address
// operation. After that, a request queue feeds a two-cycle command issuer.
// Every access takes two pin cycles: the command with the first address
// half, then a NOP that carries the second half.
// Refreshes need only a bank, so they may go out back to back during
// initialization. Only the idle cycles count toward the idle total.
// Trade-off: the row-cycle guard starts counting at the pop, so a bank is
// released one cycle later than the bare minimum. Same-bank streams lose
// a little bandwidth, and the guard stays a single compare per bank.
// Limitation: configuration, width and burst must stay steady while a
// request is in flight. Changing them mid-command mixes two mappings.
// A forbidden burst choice parks the sequencer before the entry mode set,
// so no entry mode set ever goes out with a bad setting.
// A DLL reset reuses the two-cycle mode set and skips the entry step,
// because the device is already in split-address operation by then.
module mxc_host #(
  parameter int unsigned DEPTH     = 16,
  parameter int unsigned IDLE_INIT = mxc_pkg::INIT_IDLE_COUNT
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    clockEnable,
  input  wire logic [2:0]              cfgSel,        // Configuration 1..5
  input  wire mxc_pkg::mxc_width_t     dataWidth,
  input  wire mxc_pkg::mxc_burst_t     burstLen,
  input  wire logic [9:0]              modeBits,      // User mode bits, fixed ones overridden
  input  wire logic                    dllResetReq,   // Clock or supply changed
  input  wire logic                    remuxReq,      // Re-enter mode later
  input  wire mxc_pkg::mxc_req_t       reqData,
  input  wire logic                    reqValid,
  output logic                         reqReady,
  output mxc_pkg::mxc_pins_t           memPins,
  output logic                         initDone,
  output logic                         cfgError       // Burst eight in config 1 or 4
);
  // Counter width covers the longest idle run of initialization
  localparam int unsigned CW = 11;
  // Sequencer phases, from power-up through to normal operation
  typedef enum logic [3:0] {
    ST_DUMMY, ST_ENTRY, ST_SETTLE, ST_MRS1, ST_MRS2, ST_REFRESH, ST_RUN, ST_CMD2
  } mxc_state_t;
  // Entire module state in one struct
  typedef struct packed {
    mxc_state_t          state;
    logic [CW-1:0]       count;       // Dummy, settle, idle counter
    logic [3:0]          refBank;     // Next bank to refresh during init
    logic [7:0][3:0]     bankBusy;    // Row cycle countdown per bank
    logic [7:0]          bankWrote;   // Last command to bank was a write
    logic [18:0]         secondHalf;  // Second half held for next cycle
    mxc_pkg::mxc_pins_t  pins;
    logic                done;
    logic                dllPending;
  } mxc_st_t;
  mxc_st_t s_reg;
  mxc_st_t s_next;
  // Queue head and helpers computed from the state, the queue head and the cfgSel, width, burst and mode-bit inputs
  mxc_pkg::mxc_req_t qData;
  logic              qValid;
  logic              qReady;
  logic [3:0]        rowCycle;
  logic [18:0]       mrsFirst;
  logic [18:0]       mrsSecond;
  logic [18:0]       firstHalf;
  logic [18:0]       secHalf;
  logic              bankFree;
  // Request queue in front of the command sequencer
  // Sixteen entries let the user run ahead of a busy bank; a full queue
  // stalls the user through reqReady rather than dropping a request
  mxc_fifo #(.WIDTH($bits(mxc_pkg::mxc_req_t)), .DEPTH(DEPTH)) reqFifo (
    .clock       (clock),
    .resetn      (resetn),
    .clockEnable (clockEnable),
    .inData      (reqData),
    .inValid     (reqValid),
    .inReady     (reqReady),
    .outData     (qData),
    .outValid    (qValid),
    .outReady    (qReady)
  );
  // Row cycle of the chosen configuration; unchanged from plain mode
  // Unused selector codes fall back to the fifth configuration
  always_comb begin
    case (cfgSel)
      3'h1:    rowCycle = mxc_pkg::RC_CFG1;
      3'h2:    rowCycle = mxc_pkg::RC_CFG2;
      3'h3:    rowCycle = mxc_pkg::RC_CFG3;
      3'h4:    rowCycle = mxc_pkg::RC_CFG4;
      default: rowCycle = mxc_pkg::RC_CFG5;
    endcase
  end
  // Combinational, so the user sees the error as soon as the inputs change
  // Flags a forbidden burst choice; the sequencer also withholds the entry mode set
  assign cfgError = (burstLen == mxc_pkg::MXC_BL8) && (cfgSel == 3'h1 || cfgSel == 3'h4);
  // Mode-set halves: A10..A18 zero; first half A5 high, fixed bits forced
  // The second half reuses low balls for user bits; the DLL-reset bit is
  // or-ed in while a reset request is still pending
  always_comb begin
    mrsFirst        = 19'h00000;
    mrsFirst[0]     = 1'b0;
    mrsFirst[3]     = 1'b0;
    mrsFirst[4]     = 1'b0;
    mrsFirst[5]     = 1'b1;
    mrsFirst[8]     = 1'b0;
    mrsFirst[9]     = 1'b0;
    mrsFirst[2:1]   = modeBits[1:0];
    mrsFirst[7:6]   = modeBits[3:2];
    // Second half: user bits on low balls; ball 8 is ignored by the device
    mrsSecond       = 19'h00000;
    mrsSecond[7:0]  = {1'b0, modeBits[9:3]};
    mrsSecond[9]    = 1'b0;
    mrsSecond[3]    = modeBits[4] | s_reg.dllPending; // DLL reset setting
  end
  // Split address onto balls for each half
  // Balls that carry no address bit are driven low in the second half,
  // which keeps the pins quiet and eases reading of waveforms
  always_comb begin
    firstHalf = qData.addr[18:0];
    secHalf   = 19'h00000;
    secHalf[3]  = qData.addr[1];
    secHalf[4]  = qData.addr[2];
    secHalf[8]  = qData.addr[6];
    secHalf[9]  = qData.addr[7];
    secHalf[13] = qData.addr[11];
    secHalf[14] = qData.addr[12];
    secHalf[17] = qData.addr[16];
    secHalf[18] = qData.addr[15];
    if (!((dataWidth == mxc_pkg::MXC_X36 && burstLen != mxc_pkg::MXC_BL2) ||
          (dataWidth == mxc_pkg::MXC_X18 && burstLen == mxc_pkg::MXC_BL8))) begin
      secHalf[10] = qData.addr[19];
    end
    if ((dataWidth == mxc_pkg::MXC_X18 && burstLen == mxc_pkg::MXC_BL2) ||
        (dataWidth == mxc_pkg::MXC_X9 && burstLen != mxc_pkg::MXC_BL8)) begin
      secHalf[0] = qData.addr[20];
    end
    if (dataWidth == mxc_pkg::MXC_X9 && burstLen == mxc_pkg::MXC_BL2) begin
      secHalf[5] = qData.addr[21];
    end
    if (dataWidth == mxc_pkg::MXC_X36 && burstLen == mxc_pkg::MXC_BL8) begin
      firstHalf[18] = 1'b0;
    end
  end
  // Target bank free: row cycle met, with the extra write-to-read cycle
  // A bank is free once its countdown has reached zero
  always_comb begin
    bankFree = (s_reg.bankBusy[qData.bank] == 4'h0);
    if (cfgSel == 3'h4 && !qData.isWrite && s_reg.bankWrote[qData.bank] &&
        s_reg.bankBusy[qData.bank] != 4'h0) begin
      bankFree = 1'b0;
    end
  end
  // Pops only in the run state; a pending mode request takes priority, so
  // no mode set can land between the two halves of an access
  assign qReady = (s_reg.state == ST_RUN) && qValid && bankFree && !remuxReq &&
                  !dllResetReq && clockEnable;
  // Next-state logic for the whole sequencer
  // Pins default to a NOP with all balls low unless a state drives them
  always_comb begin
    s_next          = s_reg;
    s_next.pins.cmd = mxc_pkg::MXC_NOP;
    s_next.pins.bank = 3'h0;
    s_next.pins.addr = 19'h00000;
    // Row cycle counters count down each cycle
    for (int b = 0; b < 8; b++) begin
      if (s_reg.bankBusy[b] != 4'h0) begin
        s_next.bankBusy[b] = s_reg.bankBusy[b] - 4'h1;
      end
    end
    case (s_reg.state)
      // Dummy mode sets with all address pins low
      ST_DUMMY: begin
        s_next.pins.cmd = mxc_pkg::MXC_MRS;
        s_next.count = s_reg.count + 1'b1;
        if (s_reg.count == CW'(mxc_pkg::DUMMY_MRS_COUNT - 1)) begin
          s_next.state = ST_ENTRY;
          s_next.count = '0;
        end
      end
      // Mode switch: one mode set with A5 high
      ST_ENTRY: begin
        // Parked here while the burst choice is forbidden
        if (!cfgError) begin
          s_next.pins.cmd = mxc_pkg::MXC_MRS;
          s_next.pins.addr[mxc_pkg::MUX_ENTRY_BIT] = 1'b1;
          s_next.state = ST_SETTLE;
          s_next.count = '0;
        end
      end
      // Settle wait before the two-cycle mode set
      ST_SETTLE: begin
        s_next.count = s_reg.count + 1'b1;
        if (s_reg.count >= CW'(mxc_pkg::SETTLE_CYC - 1)) begin
          s_next.state = ST_MRS1;
        end
      end
      // First mode-set half, A5 high with the fixed bits
      ST_MRS1: begin
        s_next.pins.cmd  = mxc_pkg::MXC_MRS;
        s_next.pins.addr = mrsFirst;
        s_next.state     = ST_MRS2;
      end
      // Second half rides on a NOP; a later re-entry skips the refresh phase
      ST_MRS2: begin
        s_next.pins.addr = mrsSecond;
        s_next.dllPending = 1'b0;
        s_next.count   = '0;
        s_next.refBank = 4'h0;
        s_next.state   = s_reg.done ? ST_RUN : ST_REFRESH;
        for (int b = 0; b < 8; b++) begin
          s_next.bankBusy[b] = rowCycle;
        end
      end
      // Eight bank refreshes then idles; back to back is allowed
      ST_REFRESH: begin
        if (s_reg.refBank < 4'(mxc_pkg::BANKS)) begin
          s_next.pins.cmd  = mxc_pkg::MXC_AUTO_REFRESH_CMD;
          s_next.pins.bank = s_reg.refBank[2:0];
          s_next.bankBusy[s_reg.refBank[2:0]] = rowCycle;
          s_next.bankWrote[s_reg.refBank[2:0]] = 1'b0;
          s_next.refBank = s_reg.refBank + 4'h1;
        end else begin
          // Only idle cycles count, so the full idle total follows the refreshes
          s_next.count = s_reg.count + 1'b1;
          if (s_reg.count >= CW'(IDLE_INIT - 1)) begin
            s_next.state = ST_RUN;
            s_next.done  = 1'b1;
          end
        end
      end
      // Normal operation: first half with the command
      ST_RUN: begin
        // A mode request waits until the current access has sent both halves
        if (dllResetReq || remuxReq) begin
          s_next.dllPending = dllResetReq;
          s_next.state = remuxReq ? ST_ENTRY : ST_MRS1;
        end else if (qReady) begin
          s_next.pins.cmd  = qData.isWrite ? mxc_pkg::MXC_WRITE : mxc_pkg::MXC_READ;
          s_next.pins.bank = qData.bank;
          s_next.pins.addr = firstHalf;
          s_next.secondHalf = secHalf;
          s_next.bankBusy[qData.bank] = (cfgSel == 3'h4 && qData.isWrite) ?
                                        mxc_pkg::RC_WR2RD_CFG4 : rowCycle;
          s_next.bankWrote[qData.bank] = qData.isWrite;
          s_next.state = ST_CMD2;
        end
      end
      // Second half on the following edge
      ST_CMD2: begin
        s_next.pins.addr = s_reg.secondHalf;
        s_next.state = ST_RUN;
      end
      default: s_next.state = ST_DUMMY;
    endcase
  end
  // State register; clock enable freezes everything
  // The async reset clears the pins, so the device sees NOPs during reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{state: ST_DUMMY, default: '0};
    end else if (clockEnable) begin
      s_reg <= s_next;
    end
  end
  // Pins and done come straight from the state flops, free of glitches
  assign memPins  = s_reg.pins;
  assign initDone = s_reg.done;
endmodule
`default_nettype wire

// *** mxc_host_properties.sv ***
// Pin-level checks of the multiplexed-address controller
`default_nettype none
module mxc_host_properties (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic [2:0]          cfgSel,
  input wire mxc_pkg::mxc_burst_t burstLen,
  input wire mxc_pkg::mxc_pins_t  memPins,
  input wire logic                initDone,
  input wire logic                cfgError
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic       isMrs;         // Mode set on the pins
  logic       isRw;          // Read or write on the pins
  logic       isRef;         // Auto refresh on the pins
  logic [9:0] gap;           // Row cycle of the present configuration
  logic [9:0] sinceReg [8];  // Cycles since the last command per bank
  logic [3:0] refReg;        // Refreshes counted while init runs
  // Command decode and row cycle lookup
  always_comb begin
    isMrs = memPins.cmd == mxc_pkg::MXC_MRS;
    isRef = memPins.cmd == mxc_pkg::MXC_AUTO_REFRESH_CMD;
    isRw  = memPins.cmd inside {mxc_pkg::MXC_READ, mxc_pkg::MXC_WRITE};
    case (cfgSel)
      3'h1: gap = 10'h4;
      3'h2: gap = 10'h6;
      3'h3: gap = 10'h8;
      3'h4: gap = 10'h3;
      default: gap = 10'h5;  // Unused codes act as configuration 5
    endcase
  end
  // Saturating bank ages; a wide counter avoids wrap-around false alarms
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refReg <= 4'h0;
      for (int b = 0; b < 8; b++) sinceReg[b] <= 10'h3FF;
    end else begin
      refReg <= initDone ? 4'h0 : refReg + {3'h0, isRef};
      for (int b = 0; b < 8; b++) begin
        if ((isRw || isRef) && memPins.bank == b[2:0]) sinceReg[b] <= 10'h1;
        else if (sinceReg[b] != 10'h3FF) sinceReg[b] <= sinceReg[b] + 10'h1;
      end
    end
  end
  sequence s_entry_lead;
    isMrs && memPins.addr == 19'h0 ##1 isMrs && memPins.addr == 19'h20;
  endsequence
  sequence s_entry_tail;
    memPins.cmd == mxc_pkg::MXC_NOP ##1 isMrs && memPins.addr[5];
  endsequence
  AST_ENTRY_ORDER: assert property (s_entry_lead |=> s_entry_tail)
    else $error("entry mode set not followed by settle and two-cycle mode set");
  AST_MRS_HIGH_LOW: assert property (isMrs |-> memPins.addr[18:10] == 9'h0)
    else $error("mode set with upper address bits high");
  AST_RW_SECOND_HALF: assert property (isRw |=> memPins.cmd == mxc_pkg::MXC_NOP)
    else $error("second address half overlapped by a command");
  AST_BANK_GAP: assert property (isRw || isRef |-> sinceReg[memPins.bank] >= gap)
    else $error("same bank commanded inside the row cycle");
  AST_NO_RW_IN_INIT: assert property (!initDone |-> !isRw)
    else $error("access issued before initialization ended");
  AST_INIT_REFRESH: assert property ($rose(initDone) |-> refReg == 4'h8)
    else $error("initialization ended without eight refreshes");
  AST_CFG_ERROR: assert property (cfgError ==
      (burstLen == mxc_pkg::MXC_BL8 && cfgSel inside {3'h1, 3'h4}))
    else $error("configuration error flag wrong");
  AST_ERR_NO_ENTRY: assert property (cfgError |-> !(isMrs && memPins.addr == 19'h20))
    else $error("entry mode set issued with a bad configuration");
endmodule
bind mxc_host mxc_host_properties u_props (.clock(clock), .resetn(resetn), .cfgSel(cfgSel),
  .burstLen(burstLen), .memPins(memPins), .initDone(initDone), .cfgError(cfgError));
`default_nettype wire

// *** mxc_mem_model.sv ***
// Behavioural memory that decodes the controller's split-address commands
`default_nettype none
module mxc_mem_model (
  input wire logic                clock,
  input wire logic                resetn,
  input wire logic [2:0]          cfgSel,
  input wire mxc_pkg::mxc_width_t dataWidth,
  input wire mxc_pkg::mxc_burst_t burstLen,
  input wire mxc_pkg::mxc_pins_t  memPins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        muxMode;     // Split-address decoding in force
  logic        dllOff;      // Delay-locked loop held off
  logic [7:0]  arefMask;    // Banks refreshed so far
  int          mrsCount;    // Mode sets seen
  int          rwCount;     // Accesses fully assembled
  int          violations;  // Accesses issued too early
  logic [21:0] lastAddr;    // Address built from both halves
  logic [2:0]  lastBank;    // Bank of that access
  logic        pendRw;      // Access second half due
  logic        pendMrs;     // Mode set second half due
  logic [18:0] f;           // First half kept for assembly
  int          since [8];   // Cycles since last access or refresh per bank
  logic [7:0]  lastWr;      // Last access per bank was a write
  logic        x36b8;       // Widest part at burst 8 drops its top ball
  logic        c19;
  logic        c20;
  logic        c21;
  int          need;
  // Which upper balls carry address in the second half
  assign x36b8 = dataWidth == mxc_pkg::MXC_X36 && burstLen == mxc_pkg::MXC_BL8;
  assign c19 = !(dataWidth == mxc_pkg::MXC_X36 && burstLen != mxc_pkg::MXC_BL2 ||
                 dataWidth == mxc_pkg::MXC_X18 && burstLen == mxc_pkg::MXC_BL8);
  assign c20 = dataWidth == mxc_pkg::MXC_X18 && burstLen == mxc_pkg::MXC_BL2 ||
               dataWidth == mxc_pkg::MXC_X9 && burstLen != mxc_pkg::MXC_BL8;
  assign c21 = dataWidth == mxc_pkg::MXC_X9 && burstLen == mxc_pkg::MXC_BL2;
  // Command execution one edge after issue
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {muxMode, dllOff, arefMask, pendRw, pendMrs, lastWr} <= '0;
      {mrsCount, rwCount, violations} <= '0;
      for (int b = 0; b < 8; b++) since[b] <= 1000;
    end else begin
      pendRw <= 1'b0;
      pendMrs <= 1'b0;
      for (int b = 0; b < 8; b++) since[b] <= since[b] + 1;
      if (pendRw) begin
        lastAddr <= {memPins.addr[5] & c21, memPins.addr[0] & c20, memPins.addr[10] & c19,
                     f[18] & !x36b8, f[17], memPins.addr[17], memPins.addr[18], f[14:13],
                     memPins.addr[14:13], f[10:8], memPins.addr[9:8], f[5:3],
                     memPins.addr[4:3], f[0]};
        rwCount <= rwCount + 1;
      end
      if (pendMrs) dllOff <= memPins.addr[3];  // Bank and ball 8 unused
      need = cfgSel == 3'h1 ? 4 : cfgSel == 3'h2 ? 6 : cfgSel == 3'h3 ? 8 :
             cfgSel == 3'h4 ? 3 : 5;
      case (memPins.cmd)
        mxc_pkg::MXC_MRS: begin
          mrsCount <= mrsCount + 1;
          if (!muxMode) muxMode <= memPins.addr[5];
          else pendMrs <= 1'b1;
        end
        mxc_pkg::MXC_AUTO_REFRESH_CMD: begin  // Bank only, next command may follow
          arefMask[memPins.bank] <= 1'b1;
          since[memPins.bank] <= 1;
        end
        mxc_pkg::MXC_READ, mxc_pkg::MXC_WRITE: begin
          if (cfgSel == 3'h4 && memPins.cmd == mxc_pkg::MXC_READ && lastWr[memPins.bank])
            need = 4;
          if (since[memPins.bank] < need) violations <= violations + 1;
          since[memPins.bank] <= 1;
          lastWr[memPins.bank] <= memPins.cmd == mxc_pkg::MXC_WRITE;
          pendRw <= 1'b1;
          f <= memPins.addr;
          lastBank <= memPins.bank;
        end
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** multiplexed_address_mode_tb.sv ***
// Self-checking bench for the multiplexed-address controller
`default_nettype none
module multiplexed_address_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clock = 1'b0;      // 20 MHz system clock
  logic                resetn = 1'b0;     // Held low for 20 cycles
  logic [2:0]          cfgSel = 3'h2;     // Configuration in use
  mxc_pkg::mxc_width_t dataWidth = mxc_pkg::MXC_X18;
  mxc_pkg::mxc_burst_t burstLen = mxc_pkg::MXC_BL2;
  logic                dllResetReq = 1'b0;
  logic                remuxReq = 1'b0;
  mxc_pkg::mxc_req_t   reqData = '0;
  logic                reqValid = 1'b0;
  logic                reqReady;
  mxc_pkg::mxc_pins_t  memPins;
  logic                initDone;
  logic                cfgError;
  logic                fullSeen = 1'b0;   // FIFO refused a push at least once
  int                  mismatches = 0;
  int                  checked = 0;
  int                  n;
  logic [21:0]         pat;
  // Address bits kept per width (outer) and burst (inner)
  logic [21:0] keep [9] = '{22'h0FFFFF, 22'h07FFFF, 22'h03FFFF, 22'h1FFFFF, 22'h0FFFFF,
                            22'h07FFFF, 22'h3FFFFF, 22'h1FFFFF, 22'h0FFFFF};
  always #25 clock = ~clock;
  // Remember any refusal while a request waits
  always @(posedge clock) if (reqValid && reqReady === 1'b0) fullSeen <= 1'b1;
  mxc_host #(.IDLE_INIT(16)) dut (.clock(clock), .resetn(resetn), .clockEnable(1'b1),
    .cfgSel(cfgSel), .dataWidth(dataWidth), .burstLen(burstLen), .modeBits(10'h0),
    .dllResetReq(dllResetReq), .remuxReq(remuxReq), .reqData(reqData), .reqValid(reqValid),
    .reqReady(reqReady), .memPins(memPins), .initDone(initDone), .cfgError(cfgError));
  mxc_mem_model mem (.clock(clock), .resetn(resetn), .cfgSel(cfgSel), .dataWidth(dataWidth),
    .burstLen(burstLen), .memPins(memPins));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Hold the request until the edge that takes it; caller lowers valid
  task automatic push(input logic wr, input logic [2:0] bank, input logic [21:0] addr);
    reqData <= '{wr, bank, addr};
    reqValid <= 1'b1;
    do @(posedge clock); while (reqReady !== 1'b1);
  endtask
  task automatic wait_rw(input int target);
    for (int k = 0; k < 600 && mem.rwCount < target; k++) @(posedge clock);
    check(mem.rwCount, target);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    for (int k = 0; k < 200 && initDone !== 1'b1; k++) @(posedge clock);
    check(initDone, 1);
    check(mem.muxMode, 1);
    check(mem.arefMask, 32'hFF);
    // Every width and burst, two address patterns so swapped balls show
    for (int i = 0; i < 9; i++) begin
      pat = i[0] ? 22'h355AC3 : 22'h0AA53C;
      dataWidth <= mxc_pkg::mxc_width_t'(i / 3);
      burstLen <= mxc_pkg::mxc_burst_t'(i % 3);
      push(i[0], i[2:0], pat);
      reqValid <= 1'b0;
      wait_rw(i + 1);
      check(mem.lastAddr, pat & keep[i]);
      check(mem.lastBank, i[2:0]);
    end
    dataWidth <= mxc_pkg::MXC_X18;
    burstLen <= mxc_pkg::MXC_BL2;
    n = 9;
    // Same bank back to back in each configuration, write first in the fourth;
    // each configuration uses its own bank, so a new row cycle is never judged
    // against an access that was made under the previous configuration
    for (int c = 1; c <= 5; c++) begin
      cfgSel <= c[2:0];
      push(c == 4, c[2:0], 22'h0);
      push(1'b0, c[2:0], 22'h1);
      reqValid <= 1'b0;
      n += 2;
      wait_rw(n);
    end
    check(mem.violations, 0);
    // Long row cycle stalls the drain so the FIFO fills, then empties
    cfgSel <= 3'h3;
    // Bank 6 has been idle long enough to meet the longer row cycle
    for (int k = 0; k < 24; k++) push(1'b1, 3'h6, 22'(k));
    reqValid <= 1'b0;
    wait_rw(n + 24);
    check(fullSeen, 1);
    check(reqReady, 1);
    check(mem.violations, 0);
    n = mem.mrsCount;
    remuxReq <= 1'b1;
    @(posedge clock);
    remuxReq <= 1'b0;
    for (int k = 0; k < 100 && mem.mrsCount < n + 2; k++) @(posedge clock);
    check(mem.mrsCount, n + 2);
    dllResetReq <= 1'b1;
    @(posedge clock);
    dllResetReq <= 1'b0;
    for (int k = 0; k < 100 && mem.dllOff !== 1'b1; k++) @(posedge clock);
    check(mem.dllOff, 1);
    cfgSel <= 3'h4;
    burstLen <= mxc_pkg::MXC_BL8;
    @(posedge clock);
    check(cfgError, 1);
    // A forbidden burst choice must hold back the entry mode set
    n = mem.mrsCount;
    remuxReq <= 1'b1;
    repeat (10) @(posedge clock);
    remuxReq <= 1'b0;
    check(mem.mrsCount, n);
    give_verdict();
  end
endmodule
`default_nettype wire
